//--- src/rdps_cfg.sv
// rom decode and shared-pin select configuration registers
// assumes the host index/data port logic delivers a decoded index and strobes
// on clk_in; straps are raw pins and are synchronised here
`timescale 1ns/100ps
`include "rdps_regs.svh"

// Summary of operation
// - bit7 clear blocks firmware ROM writes
// - bit6 enables flash, strap low enables
// - bit5 zero selects flash boot source
// - bit4 picks port 2E or 4E
// - bit3 decodes E segment window
// - bit2 decodes top 512K and F segment
// - bit1 decodes FFEE to FFEF window
// - bit3 to bit1 decode enables loaded from decode strap
// - bit0 decodes FFF0 window, resets zero
// - bit6 routes pins to voltage ID
// - voltage ID enable loaded from strap
// - bit3 selects infrared receive or GPIO43
// - bit2 selects infrared transmit or GPIO42
// - bit1 selects fan3 control or GPIO41
// - bit0 selects fan3 tach or GPIO40
module rdps_cfg
  import rdps_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  cfg_index_in,
  input  wire logic [7:0]  cfg_wdata_in,
  input  wire logic        cfg_write_in,
  input  wire logic        cfg_read_in,
  output logic [7:0]       cfg_rdata_out,
  output logic             cfg_hit_out,
  input  wire logic        serial_out2_flash_strap_in,
  input  wire logic        dtr2_boot_strap_in,
  input  wire logic        serial_out1_port_strap_in,
  input  wire logic        serial_out2_decode_strap_in,
  input  wire logic        rts1_voltage_id_strap_in,
  input  wire logic [31:0] mem_addr_in,
  input  wire logic        mem_valid_in,
  input  wire logic        mem_write_in,
  output logic             mem_claim_out,
  output logic             rom_write_allow_out,
  output logic             flash_enable_out,
  output logic             boot_source_select_out,
  output logic             alt_config_port_select_out,
  output logic [15:0]      config_port_base_out,
  output logic             voltage_id_out_enable_out,
  output logic             ir_receive_pin_select_out,
  output logic             ir_transmit_pin_select_out,
  output logic             fan3_control_pin_select_out,
  output logic             fan3_tach_pin_select_out,
  output logic             straps_loaded_out
);
  // ====================
  // strap synchronisers
  logic s_flash;
  logic s_boot;
  logic s_port;
  logic s_decode;
  logic s_vid;

  rdps_sync u_sync_flash (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (serial_out2_flash_strap_in),
    .sync_out (s_flash)
  );
  rdps_sync u_sync_boot (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (dtr2_boot_strap_in),
    .sync_out (s_boot)
  );
  rdps_sync u_sync_port (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (serial_out1_port_strap_in),
    .sync_out (s_port)
  );
  rdps_sync u_sync_decode (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (serial_out2_decode_strap_in),
    .sync_out (s_decode)
  );
  rdps_sync u_sync_vid (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (rts1_voltage_id_strap_in),
    .sync_out (s_vid)
  );

  // ====================
  // register state
  // synchronisers sit in reset with the rest, so a strap reaches
  // the second flop only after two edges; LOAD waits two idle cycles.
  // writes before then are dropped
  rdps_state_t state;
  rdps_state_t next_state;
  logic        settled;
  logic        next_settled;
  logic [7:0]  rom_address_select;
  logic [7:0]  power_led_function_select;
  logic [7:0]  next_rom;
  logic [7:0]  next_pin;
  logic [7:0]  next_rdata;
  logic        next_hit;
  logic [7:0]  rdata;
  logic        hit;

  always_comb begin
    next_state = state;
    next_settled = settled;
    next_rom   = rom_address_select;
    next_pin   = power_led_function_select;
    next_rdata = rdata;
    next_hit   = 1'b0;
    case (state)
      RDPS_ST_IDLE: begin
        next_settled = 1'b1;
        if (settled) begin
          next_state = RDPS_ST_LOAD;
        end
      end
      RDPS_ST_LOAD: begin
        // pulled-low straps select enabled / low-port / flash-boot
        next_rom[`RDPS_ROM_WR_BIT]    = 1'b0;
        next_rom[`RDPS_FLASH_EN_BIT]  = ~s_flash;
        next_rom[`RDPS_BOOT_SRC_BIT]  = s_boot;
        next_rom[`RDPS_ALT_PORT_BIT]  = s_port;
        next_rom[`RDPS_SEG_E_BIT]     = ~s_decode;
        next_rom[`RDPS_TOP512_BIT]    = ~s_decode;
        next_rom[`RDPS_UPPER_WIN_BIT] = ~s_decode;
        next_rom[`RDPS_MID_WIN_BIT]   = 1'b0;
        next_pin = `RDPS_RESET_BYTE;
        // low strap leaves the pins as gpio
        next_pin[`RDPS_VID_EN_BIT]    = s_vid;
        next_state = RDPS_ST_RUN;
      end
      RDPS_ST_RUN: begin
        if (cfg_write_in && cfg_index_in == `RDPS_IDX_ROM_SEL) begin
          next_rom = cfg_wdata_in;
        end
        if (cfg_write_in && cfg_index_in == `RDPS_IDX_PIN_SEL) begin
          next_pin = cfg_wdata_in & `RDPS_PIN_SEL_MASK;
        end
        if (cfg_read_in) begin
          next_hit = (cfg_index_in == `RDPS_IDX_ROM_SEL) ||
                     (cfg_index_in == `RDPS_IDX_PIN_SEL);
          case (cfg_index_in)
            `RDPS_IDX_ROM_SEL: next_rdata = rom_address_select;
            `RDPS_IDX_PIN_SEL: next_rdata = power_led_function_select;
            default:           next_rdata = `RDPS_RESET_BYTE;
          endcase
        end
      end
      default: begin
        next_state = RDPS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state                     <= RDPS_ST_IDLE;
      settled                   <= 1'b0;
      rom_address_select        <= `RDPS_RESET_BYTE;
      power_led_function_select <= `RDPS_RESET_BYTE;
      rdata                     <= `RDPS_RESET_BYTE;
      hit                       <= 1'b0;
    end else begin
      state                     <= next_state;
      settled                   <= next_settled;
      rom_address_select        <= next_rom;
      power_led_function_select <= next_pin;
      rdata                     <= next_rdata;
      hit                       <= next_hit;
    end
  end

  // ====================
  // address window decode
  function automatic logic in_window(input logic [31:0] a, input logic [7:0] r);
    logic e_hit;
    logic top_hit;
    logic upper_hit;
    logic mid_hit;
    e_hit     = r[`RDPS_SEG_E_BIT] && a[31:16] == `RDPS_SEG_E_BASE;
    top_hit   = r[`RDPS_TOP512_BIT] && (a[31:19] == `RDPS_TOP512_BASE ||
                                        a[31:16] == `RDPS_SEG_F_BASE);
    upper_hit = r[`RDPS_UPPER_WIN_BIT] && a[31:17] == `RDPS_UPPER_WIN_BASE;
    mid_hit   = r[`RDPS_MID_WIN_BIT] && a[31:19] == `RDPS_MID_WIN_BASE;
    in_window = e_hit | top_hit | upper_hit | mid_hit;
  endfunction

  logic claim;
  logic next_claim;

  always_comb begin
    next_claim = 1'b0;
    if (mem_valid_in && in_window(mem_addr_in, rom_address_select)) begin
      // a write to a claimed window is only taken while writes are allowed
      next_claim = !mem_write_in || rom_address_select[`RDPS_ROM_WR_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      claim <= 1'b0;
    end else begin
      claim <= next_claim;
    end
  end

  // ====================
  // outputs
  assign cfg_rdata_out               = rdata;
  assign cfg_hit_out                 = hit;
  assign mem_claim_out               = claim;
  assign straps_loaded_out           = (state == RDPS_ST_RUN);
  assign rom_write_allow_out         = rom_address_select[`RDPS_ROM_WR_BIT];
  assign flash_enable_out            = rom_address_select[`RDPS_FLASH_EN_BIT];
  assign boot_source_select_out      = rom_address_select[`RDPS_BOOT_SRC_BIT];
  assign alt_config_port_select_out  = rom_address_select[`RDPS_ALT_PORT_BIT];
  assign config_port_base_out        = rom_address_select[`RDPS_ALT_PORT_BIT] ?
                                       `RDPS_PORT_BASE_HIGH : `RDPS_PORT_BASE_LOW;
  assign voltage_id_out_enable_out   = power_led_function_select[`RDPS_VID_EN_BIT];
  assign ir_receive_pin_select_out   = power_led_function_select[`RDPS_IR_RX_BIT];
  assign ir_transmit_pin_select_out  = power_led_function_select[`RDPS_IR_TX_BIT];
  assign fan3_control_pin_select_out = power_led_function_select[`RDPS_FAN3_CTL_BIT];
  assign fan3_tach_pin_select_out    = power_led_function_select[`RDPS_FAN3_TACH_BIT];
endmodule

//--- src/rdps_regs.svh
// register offsets, field positions and decode windows for the rom/pin select bank
// assumes an 8-bit configuration index space reached through the index/data port
`ifndef RDPS_REGS_SVH
`define RDPS_REGS_SVH

// ====================
// register indices
`define RDPS_IDX_ROM_SEL      8'h27
`define RDPS_IDX_PIN_SEL      8'h28

// ====================
// rom address select fields
`define RDPS_ROM_WR_BIT       7
`define RDPS_FLASH_EN_BIT     6
`define RDPS_BOOT_SRC_BIT     5
`define RDPS_ALT_PORT_BIT     4
`define RDPS_SEG_E_BIT        3
`define RDPS_TOP512_BIT       2
`define RDPS_UPPER_WIN_BIT    1
`define RDPS_MID_WIN_BIT      0

// ====================
// power led function select fields
`define RDPS_VID_EN_BIT       6
`define RDPS_IR_RX_BIT        3
`define RDPS_IR_TX_BIT        2
`define RDPS_FAN3_CTL_BIT     1
`define RDPS_FAN3_TACH_BIT    0
`define RDPS_PIN_SEL_MASK     8'h4f

// ====================
// config port pairs
`define RDPS_PORT_BASE_LOW    16'h002e
`define RDPS_PORT_BASE_HIGH   16'h004e

// ====================
// decode windows, upper address bits compared
`define RDPS_SEG_E_BASE       16'h000e
`define RDPS_SEG_F_BASE       16'h000f
`define RDPS_TOP512_BASE      13'h1fff
`define RDPS_UPPER_WIN_BASE   15'h7ff7
`define RDPS_MID_WIN_BASE     13'h1ffe

`define RDPS_RESET_BYTE       8'h00

`endif

//--- src/rdps_pkg.sv
// types shared by the rom/pin select bank
// assumes the _regs header supplies all numeric constants
package rdps_pkg;
  typedef enum logic [1:0] {
    RDPS_ST_IDLE,
    RDPS_ST_LOAD,
    RDPS_ST_RUN
  } rdps_state_t;
endpackage

//--- src/rdps_sync.sv
// two-flop synchroniser for strap pins
// assumes straps are asynchronous to clk_in
`timescale 1ns/100ps
module rdps_sync
  import rdps_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;
  logic next_stage1;
  logic next_sync;

  always_comb begin
    next_stage1 = async_in;
    next_sync   = stage1;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync;
    end
  end
endmodule

//--- verification/rdps_host_model.sv
// host side of the configuration index/data port, one strobe per request
// assumes the bench raises req_in for one clk_in cycle per operation
`timescale 1ns/100ps
module rdps_host_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       req_in,
  input  wire logic       req_wr_in,
  input  wire logic [7:0] req_idx_in,
  input  wire logic [7:0] req_dat_in,
  output logic [7:0]      index_out,
  output logic [7:0]      wdata_out,
  output logic            write_out,
  output logic            read_out
);
  // idle bus shows the inverse of its last value so stale bytes cannot pass
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      {write_out, read_out, index_out, wdata_out} <= 18'h0;
    end else begin
      write_out <= req_in & req_wr_in;
      read_out  <= req_in & ~req_wr_in;
      index_out <= req_in ? req_idx_in : ~index_out;
      wdata_out <= req_in ? req_dat_in : ~wdata_out;
    end
  end
endmodule

//--- verification/rdps_cfg_props.sv
// concurrent checks on the ports of the rom/pin select bank
// assumes straps stay steady around every reset release
`timescale 1ns/100ps
module rdps_cfg_props (
  input wire logic        clk_in, rst_in, cfg_read_in, cfg_hit_out, mem_valid_in, mem_write_in,
  input wire logic        mem_claim_out, rom_write_allow_out, flash_enable_out, straps_loaded_out,
  input wire logic        boot_source_select_out, alt_config_port_select_out,
  input wire logic        voltage_id_out_enable_out, ir_receive_pin_select_out,
  input wire logic        ir_transmit_pin_select_out, fan3_control_pin_select_out,
  input wire logic        fan3_tach_pin_select_out, serial_out2_flash_strap_in,
  input wire logic        dtr2_boot_strap_in, serial_out1_port_strap_in, rts1_voltage_id_strap_in,
  input wire logic [7:0]  cfg_index_in, cfg_rdata_out,
  input wire logic [15:0] config_port_base_out,
  input wire logic [31:0] mem_addr_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [3:0] pins;
  logic       in_win;
  assign pins = {ir_receive_pin_select_out, ir_transmit_pin_select_out,
                 fan3_control_pin_select_out, fan3_tach_pin_select_out};
  assign in_win = mem_addr_in[31:17] == 15'h0007 || mem_addr_in[31:19] == 13'h1fff
                  || mem_addr_in[31:17] == 15'h7ff7 || mem_addr_in[31:19] == 13'h1ffe;
  // ====================
  // read path
  property p_rom_rd; cfg_hit_out && $past(cfg_index_in) == 8'h27 |-> cfg_rdata_out[7:4] ==
    $past({rom_write_allow_out, flash_enable_out, boot_source_select_out,
    alt_config_port_select_out}); endproperty
  a_rom_rd: assert property (p_rom_rd) else $error("rom select readback");
  property p_pin_rd; cfg_hit_out && $past(cfg_index_in) == 8'h28 |-> cfg_rdata_out ==
    {1'b0, $past(voltage_id_out_enable_out), 2'b00, $past(pins)}; endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin select readback");
  property p_hit; cfg_hit_out |-> $past(cfg_read_in) && $past(cfg_index_in) inside {8'h27, 8'h28};
  endproperty
  a_hit: assert property (p_hit) else $error("hit without mapped read");
  property p_port; config_port_base_out == (alt_config_port_select_out ? 16'h004e : 16'h002e);
  endproperty
  a_port: assert property (p_port) else $error("config port base");
  // ====================
  // memory decode and straps
  property p_wr_gate; mem_valid_in && mem_write_in && !rom_write_allow_out |=> !mem_claim_out;
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("rom write claimed");
  property p_outside; mem_valid_in && !in_win |=> !mem_claim_out; endproperty
  a_outside: assert property (p_outside) else $error("claim outside windows");
  property p_strap; $rose(straps_loaded_out) |-> flash_enable_out == !serial_out2_flash_strap_in
    && boot_source_select_out == dtr2_boot_strap_in && alt_config_port_select_out ==
    serial_out1_port_strap_in && voltage_id_out_enable_out == rts1_voltage_id_strap_in;
  endproperty
  a_strap: assert property (p_strap) else $error("strap load");
  property p_rst_val; $rose(straps_loaded_out) |-> !rom_write_allow_out && pins == 4'h0;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset value");
endmodule

bind rdps_cfg rdps_cfg_props chk_u (
  .clk_in                      (clk_in),
  .rst_in                      (rst_in),
  .cfg_read_in                 (cfg_read_in),
  .cfg_hit_out                 (cfg_hit_out),
  .mem_valid_in                (mem_valid_in),
  .mem_write_in                (mem_write_in),
  .mem_claim_out               (mem_claim_out),
  .rom_write_allow_out         (rom_write_allow_out),
  .flash_enable_out            (flash_enable_out),
  .straps_loaded_out           (straps_loaded_out),
  .boot_source_select_out      (boot_source_select_out),
  .alt_config_port_select_out  (alt_config_port_select_out),
  .voltage_id_out_enable_out   (voltage_id_out_enable_out),
  .ir_receive_pin_select_out   (ir_receive_pin_select_out),
  .ir_transmit_pin_select_out  (ir_transmit_pin_select_out),
  .fan3_control_pin_select_out (fan3_control_pin_select_out),
  .fan3_tach_pin_select_out    (fan3_tach_pin_select_out),
  .serial_out2_flash_strap_in  (serial_out2_flash_strap_in),
  .dtr2_boot_strap_in          (dtr2_boot_strap_in),
  .serial_out1_port_strap_in   (serial_out1_port_strap_in),
  .rts1_voltage_id_strap_in    (rts1_voltage_id_strap_in),
  .cfg_index_in                (cfg_index_in),
  .cfg_rdata_out               (cfg_rdata_out),
  .config_port_base_out        (config_port_base_out),
  .mem_addr_in                 (mem_addr_in)
);

//--- verification/rdps_cfg_tb_top.sv
// self-checking bench for the rom/pin select bank against a register image
// assumes the host model and the bound checker sit beside the design
`timescale 1ns/100ps
module rdps_cfg_tb_top;
  logic clk_in = 1'b0, rst_in = 1'b1, mem_valid_in = 1'b0, mem_write_in = 1'b0;
  logic cfg_write_in, cfg_read_in, cfg_hit_out, mem_claim_out, rom_write_allow_out;
  logic flash_enable_out, boot_source_select_out, alt_config_port_select_out;
  logic voltage_id_out_enable_out, ir_receive_pin_select_out, ir_transmit_pin_select_out;
  logic fan3_control_pin_select_out, fan3_tach_pin_select_out, straps_loaded_out;
  logic serial_out2_flash_strap_in, dtr2_boot_strap_in, serial_out1_port_strap_in;
  logic serial_out2_decode_strap_in, rts1_voltage_id_strap_in, req = 1'b0, req_wr = 1'b0;
  logic [7:0]  cfg_index_in, cfg_wdata_in, cfg_rdata_out, req_idx = 8'h0, req_dat = 8'h0;
  logic [7:0]  m27, m28, d, k;
  logic [4:0]  straps;
  logic [15:0] config_port_base_out;
  logic [31:0] mem_addr_in = 32'h0;
  logic [31:0] addrs [13] = '{32'h000dffff, 32'h000e0000, 32'h000effff, 32'h000f0000,
    32'h000fffff, 32'h00100000, 32'hffedffff, 32'hffee0000, 32'hffefffff, 32'hfff00000,
    32'hfff7ffff, 32'hfff80000, 32'hffffffff};
  int failures = 0, checked = 0, seed = 32'hfb099590;
  assign {serial_out2_flash_strap_in, dtr2_boot_strap_in, serial_out1_port_strap_in,
          serial_out2_decode_strap_in, rts1_voltage_id_strap_in} = straps;
  wire [3:0] rom_hi = {rom_write_allow_out, flash_enable_out, boot_source_select_out,
                       alt_config_port_select_out};
  wire [4:0] pins = {voltage_id_out_enable_out, ir_receive_pin_select_out,
                     ir_transmit_pin_select_out, fan3_control_pin_select_out,
                     fan3_tach_pin_select_out};
  always #2.5 clk_in = ~clk_in;
  rdps_cfg dut_u (.*);
  rdps_host_model host_u (.clk_in(clk_in), .rst_in(rst_in), .req_in(req), .req_wr_in(req_wr),
    .req_idx_in(req_idx), .req_dat_in(req_dat), .index_out(cfg_index_in),
    .wdata_out(cfg_wdata_in), .write_out(cfg_write_in), .read_out(cfg_read_in));
  // ====================
  // helpers
  function automatic logic exp_claim(input logic [31:0] a, input logic w);
    logic hit;
    hit = (a >= 32'h000e0000 && a <= 32'h000effff && m27[3])
       || ((a >= 32'h000f0000 && a <= 32'h000fffff || a >= 32'hfff80000) && m27[2])
       || (a >= 32'hffee0000 && a <= 32'hffefffff && m27[1])
       || (a >= 32'hfff00000 && a <= 32'hfff7ffff && m27[0]);
    return hit && (!w || m27[7]);
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task op(input logic wr, input logic [7:0] idx, input logic [7:0] dat);
    @(posedge clk_in);
    {req, req_wr, req_idx, req_dat} <= {1'b1, wr, idx, dat};
    @(posedge clk_in) req <= 1'b0;
    @(posedge clk_in) #1;
  endtask
  task chk_outs;
    chk(rom_hi, m27[7:4]);
    chk(pins, {m28[6], m28[3:0]});
    chk(config_port_base_out, m27[4] ? 16'h004e : 16'h002e);
    op(1'b0, 8'h27, 8'h00);
    chk({cfg_hit_out, cfg_rdata_out}, {1'b1, m27});
    op(1'b0, 8'h28, 8'h00);
    chk({cfg_hit_out, cfg_rdata_out}, {1'b1, m28});
  endtask
  task give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ====================
  // sequence: two strap patterns, each followed by random register traffic
  initial begin
    straps = 5'($random(seed));
    for (int pass = 0; pass < 2; pass++) begin
      @(posedge clk_in) {rst_in, straps} <= {1'b1, pass ? ~straps : straps};
      repeat (2) @(posedge clk_in);
      chk(straps_loaded_out, 32'h0);
      rst_in <= 1'b0;
      m27 = {1'b0, !straps[4], straps[3], straps[2], {3{!straps[1]}}, 1'b0};
      m28 = {1'b0, straps[0], 6'h00};
      // straps land on the third edge after release
      repeat (4) @(posedge clk_in);
      #1 chk(straps_loaded_out, 32'h1);
      chk_outs;
      for (int i = 0; i < 10; i++) begin
        d = 8'($random(seed));
        k = 8'($random(seed));
        op(1'b1, 8'h27, d);
        m27 = d;
        op(1'b1, 8'h28, k);
        m28 = k & 8'h4f;
        op(1'b1, 8'h26, ~k);
        op(1'b0, 8'h26, 8'h00);
        chk({cfg_hit_out, cfg_rdata_out}, 9'h000);
        chk_outs;
        foreach (addrs[j]) begin
          @(posedge clk_in);
          {mem_valid_in, mem_write_in, mem_addr_in} <= {1'b1, 1'($random(seed)), addrs[j]};
          @(posedge clk_in) mem_valid_in <= 1'b0;
          #1 chk(mem_claim_out, exp_claim(mem_addr_in, mem_write_in));
        end
      end
    end
    give_verdict;
  end
  // hang guard, far beyond the roughly 900 cycles the sequence needs
  initial begin
    #100000;
    failures++;
    give_verdict;
  end
endmodule
